// [nvm_access_ctrl.sv]
// Control register block for self-timed nonvolatile memory access.
// Assumes the core drives the register port and the memory array follows mem_cmd.
`timescale 1ns/100ps
`default_nettype none
module nvm_access_ctrl #(
   parameter int WRITE_CYCLES = 4000
) (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [7:0]        reg_rdata,
   input  wire logic [7:0]        mem_rdata,
   input  wire logic              abort_write,
   output var  nvm_pkg::mem_cmd_type mem_cmd,
   output var  logic              irq
);
   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0] addr_low_r;
   logic [7:0] addr_high_r;
   logic [7:0] data_r;
   logic       prog_sel_r;
   logic       cfg_sel_r;
   logic       row_erase_r;
   logic       wr_err_r;
   logic       wr_en_r;
   logic       wr_start_r;
   logic [nvm_pkg::IRQ_W-1:0] irq_stat_r;
   logic [nvm_pkg::IRQ_W-1:0] irq_en_r;
   nvm_pkg::reg_req_type req;
   nvm_pkg::space_type space;
   logic       armed;
   logic       busy;
   logic       done;
   logic       ctrl_wr;
   logic       start_go;
   logic       improper;
   logic       read_go;
   logic       aborted;

   assign req      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
   assign ctrl_wr  = reg_wr && reg_addr == nvm_pkg::OFS_CONTROL;
   // ************************************************************
   // Space select and start qualification
   // ************************************************************
   assign space = cfg_sel_r ? nvm_pkg::SPACE_CONFIG : (prog_sel_r ? nvm_pkg::SPACE_FLASH : nvm_pkg::SPACE_EEPROM);
   assign start_go = ctrl_wr && reg_wdata[nvm_pkg::BIT_WR_START] && !wr_start_r && armed
                     && reg_wdata[nvm_pkg::BIT_WR_EN] && wr_en_r;
   assign improper = ctrl_wr && reg_wdata[nvm_pkg::BIT_WR_START] && !wr_start_r && !start_go;
   assign read_go  = ctrl_wr && reg_wdata[nvm_pkg::BIT_RD_START] && !reg_wdata[nvm_pkg::BIT_PROG_SEL]
                     && !reg_wdata[nvm_pkg::BIT_CFG_SEL] && !busy;
   assign aborted  = busy && abort_write;

   nvm_unlock_seq u_unlock (
      .mclk  (mclk),
      .reset (reset),
      .req   (req),
      .armed (armed)
   );

   nvm_cycle_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
      .mclk  (mclk),
      .reset (reset),
      .start (start_go),
      .abort (aborted),
      .busy  (busy),
      .done  (done)
   );

   // ************************************************************
   // Control register
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prog_sel_r  <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_PROG_SEL];
         cfg_sel_r   <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_CFG_SEL];
         wr_en_r     <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_WR_EN];
      end else if (ctrl_wr && !busy) begin
         prog_sel_r  <= reg_wdata[nvm_pkg::BIT_PROG_SEL];
         cfg_sel_r   <= reg_wdata[nvm_pkg::BIT_CFG_SEL];
         wr_en_r     <= reg_wdata[nvm_pkg::BIT_WR_EN];
      end else if (ctrl_wr) begin
         wr_en_r     <= reg_wdata[nvm_pkg::BIT_WR_EN];
      end
   end

   // Row erase clears itself once any erase or write cycle finishes
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         row_erase_r <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_ROW_ERASE];
      end else if (done && row_erase_r) begin
         row_erase_r <= 1'b0;
      end else if (ctrl_wr && !busy) begin
         row_erase_r <= reg_wdata[nvm_pkg::BIT_ROW_ERASE];
      end
   end

   // Write start: software sets, hardware clears
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_start_r <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_WR_START];
      end else if (start_go) begin
         wr_start_r <= 1'b1;
      end else if (done || aborted) begin
         wr_start_r <= 1'b0;
      end
   end

   // Error flag; software may clear it, an abort in the same cycle wins
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_err_r <= nvm_pkg::CONTROL_RESET[nvm_pkg::BIT_WR_ERR];
      end else if (aborted || improper) begin
         wr_err_r <= 1'b1;
      end else if (ctrl_wr) begin
         wr_err_r <= reg_wdata[nvm_pkg::BIT_WR_ERR];
      end
   end

   // ************************************************************
   // Address and data registers
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         addr_low_r  <= 8'h00;
         addr_high_r <= 8'h00;
      end else if (reg_wr && !busy) begin
         if (reg_addr == nvm_pkg::OFS_ADDR_LOW) addr_low_r <= reg_wdata;
         else if (reg_addr == nvm_pkg::OFS_ADDR_HIGH) addr_high_r <= reg_wdata;
      end
   end

   // Read result lands one cycle after the read command
   logic read_pend_r;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         read_pend_r <= 1'b0;
      end else begin
         read_pend_r <= read_go;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         data_r <= 8'h00;
      end else if (read_pend_r) begin
         data_r <= mem_rdata;
      end else if (reg_wr && reg_addr == nvm_pkg::OFS_DATA && !busy) begin
         data_r <= reg_wdata;
      end
   end

   // ************************************************************
   // Memory command
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mem_cmd <= '0;
      end else begin
         mem_cmd.start <= start_go || read_go;
         mem_cmd.erase <= start_go && row_erase_r && space == nvm_pkg::SPACE_FLASH;
         mem_cmd.write <= start_go && !(row_erase_r && space == nvm_pkg::SPACE_FLASH);
         mem_cmd.read  <= read_go;
         mem_cmd.space <= read_go ? nvm_pkg::SPACE_EEPROM : space;
         mem_cmd.addr  <= {addr_high_r, addr_low_r};
         mem_cmd.data  <= data_r;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   logic irq_clr_wr;
   assign irq_clr_wr = reg_wr && reg_addr == nvm_pkg::OFS_IRQ_CLR;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_stat_r <= '0;
      end else begin
         // Set wins over a clear in the same cycle
         irq_stat_r[nvm_pkg::IRQ_DONE]  <= done ||
            (irq_stat_r[nvm_pkg::IRQ_DONE] && !(irq_clr_wr && reg_wdata[nvm_pkg::IRQ_DONE]));
         irq_stat_r[nvm_pkg::IRQ_ERROR] <= (aborted || improper) ||
            (irq_stat_r[nvm_pkg::IRQ_ERROR] && !(irq_clr_wr && reg_wdata[nvm_pkg::IRQ_ERROR]));
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_en_r <= '0;
      end else if (reg_wr && reg_addr == nvm_pkg::OFS_IRQ_EN) begin
         irq_en_r <= reg_wdata[nvm_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_en_r);
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == nvm_pkg::OFS_CONTROL) begin
            reg_rdata <= {prog_sel_r, cfg_sel_r, 1'b0, row_erase_r, wr_err_r, wr_en_r, wr_start_r, 1'b0};
         end else if (reg_addr == nvm_pkg::OFS_ADDR_LOW) begin
            reg_rdata <= addr_low_r;
         end else if (reg_addr == nvm_pkg::OFS_ADDR_HIGH) begin
            reg_rdata <= addr_high_r;
         end else if (reg_addr == nvm_pkg::OFS_DATA) begin
            reg_rdata <= data_r;
         end else if (reg_addr == nvm_pkg::OFS_IRQ_STAT) begin
            reg_rdata <= {6'h00, irq_stat_r};
         end else if (reg_addr == nvm_pkg::OFS_IRQ_EN) begin
            reg_rdata <= {6'h00, irq_en_r};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : nvm_access_ctrl
`default_nettype wire

// [nvm_access_ctrl_assertions.sv]
// Port assertions for the nonvolatile access controller.
// Assumes one mclk domain and at most one register access per cycle.
`timescale 1ns/100ps
`default_nettype none
module nvm_access_ctrl_assertions #(
   parameter int WRITE_CYCLES = 4000
) (
   input wire logic                 mclk,
   input wire logic                 reset,
   input wire logic [3:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   input wire logic [7:0]           mem_rdata,
   input wire logic                 abort_write,
   input wire nvm_pkg::mem_cmd_type mem_cmd,
   input wire logic                 irq
);
   logic       go;
   logic       ctl_wr;
   logic       first_r;
   logic       armed_r;
   logic [7:0] cw_r;
   assign go = mem_cmd.write || mem_cmd.erase;
   assign ctl_wr = reg_wr && reg_addr == nvm_pkg::OFS_CONTROL;
   // ************************************************************
   // Unlock history and the control byte of the last armed start
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         first_r <= 1'b0;
         armed_r <= 1'b0;
         cw_r <= 8'h00;
      end else if (reg_wr || reg_rd) begin
         first_r <= reg_wr && reg_addr == nvm_pkg::OFS_UNLOCK && reg_wdata == nvm_pkg::UNLOCK_FIRST;
         armed_r <= first_r && reg_wr && reg_addr == nvm_pkg::OFS_UNLOCK && reg_wdata == nvm_pkg::UNLOCK_SECOND;
         if (armed_r && ctl_wr) begin
            cw_r <= reg_wdata;
         end
      end
   end
   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence quiet_s;
      !go [*8];
   endsequence
   sequence launch_s;
      go ##1 quiet_s;
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   read_cause_a: assert property (mem_cmd.read |-> $past(ctl_wr && reg_wdata[nvm_pkg::BIT_RD_START]))
      else $error("read command without a read start");
   read_space_a: assert property (mem_cmd.read |-> mem_cmd.space == nvm_pkg::SPACE_EEPROM)
      else $error("read command with a space select set");
   unlock_order_a: assert property (go |-> $past(armed_r && ctl_wr) || $past(armed_r && ctl_wr, 2))
      else $error("write cycle without unlock pair before start");
   write_en_a: assert property (go |-> cw_r[nvm_pkg::BIT_WR_EN])
      else $error("write cycle with write enable low");
   space_sel_a: assert property (go |-> mem_cmd.space == (cw_r[6] ? nvm_pkg::SPACE_CONFIG :
      cw_r[7] ? nvm_pkg::SPACE_FLASH : nvm_pkg::SPACE_EEPROM))
      else $error("write cycle aimed at wrong space");
   erase_flash_a: assert property (mem_cmd.erase |-> mem_cmd.space == nvm_pkg::SPACE_FLASH && cw_r[4])
      else $error("row erase outside flash or without erase enable");
   rewrite_gap_a: assert property (go |-> launch_s)
      else $error("second cycle launched while busy");
   irq_mask_a: assert property (reg_wr && reg_addr == nvm_pkg::OFS_IRQ_EN && reg_wdata[1:0] == 2'b00 |-> ##[1:2] !irq)
      else $error("interrupt high with all sources disabled");
endmodule : nvm_access_ctrl_assertions

bind nvm_access_ctrl nvm_access_ctrl_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvm_access_ctrl_assertions (
   .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .abort_write(abort_write),
   .mem_cmd(mem_cmd), .irq(irq));
`default_nettype wire

// [nvm_cycle_timer.sv]
// Down counter timing one self-timed erase or write cycle.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/100ps
`default_nettype none
module nvm_cycle_timer #(
   parameter int CYCLES = 4000
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic start,
   input  wire logic abort,
   output var  logic busy,
   output var  logic done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count_r;
   assign busy = (count_r != '0);
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count_r <= '0;
         done    <= 1'b0;
      end else if (abort) begin
         // A cut-short cycle stops at once and never reports completion
         count_r <= '0;
         done    <= 1'b0;
      end else begin
         done <= (count_r == W'(1));
         if (start) count_r <= W'(CYCLES);
         else if (busy) count_r <= count_r - W'(1);
      end
   end
endmodule : nvm_cycle_timer
`default_nettype wire

// [nvm_pkg.sv]
// Constants, register map and carriers for the nonvolatile access controller.
// Assumes a plain register port driven by the core and a self-timed memory array outside.
`default_nettype none
package nvm_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [3:0] OFS_CONTROL   = 4'h0;
   localparam logic [3:0] OFS_UNLOCK    = 4'h1;
   localparam logic [3:0] OFS_ADDR_LOW  = 4'h2;
   localparam logic [3:0] OFS_ADDR_HIGH = 4'h3;
   localparam logic [3:0] OFS_DATA      = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT  = 4'h5;
   localparam logic [3:0] OFS_IRQ_CLR   = 4'h6;
   localparam logic [3:0] OFS_IRQ_EN    = 4'h7;
   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int BIT_PROG_SEL  = 7;
   localparam int BIT_CFG_SEL   = 6;
   localparam int BIT_ROW_ERASE = 4;
   localparam int BIT_WR_ERR    = 3;
   localparam int BIT_WR_EN     = 2;
   localparam int BIT_WR_START  = 1;
   localparam int BIT_RD_START  = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'haa;
   // Interrupt status bits
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_ERROR = 1;
   localparam int IRQ_W     = 2;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {SPACE_EEPROM, SPACE_FLASH, SPACE_CONFIG} space_type;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
   typedef struct packed {
      logic       start;
      logic       erase;
      logic       write;
      logic       read;
      space_type  space;
      logic [15:0] addr;
      logic [7:0] data;
   } mem_cmd_type;
endpackage : nvm_pkg
`default_nettype wire

// [nvm_unlock_seq.sv]
// Unlock sequence tracker for write start arming.
// Assumes one register request per cycle at most.
`timescale 1ns/100ps
`default_nettype none
module nvm_unlock_seq (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire nvm_pkg::reg_req_type req,
   output var  logic              armed
);
   typedef enum logic [1:0] {IDLE, GOT_FIRST, ARMED} unlock_state_type;
   unlock_state_type state_r;
   assign armed = (state_r == ARMED);
   // Any bus write or read other than the next expected step or a repeated first key breaks the sequence
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= IDLE;
      end else if (req.wr) begin
         case (state_r)
            IDLE: begin
               if (req.addr == nvm_pkg::OFS_UNLOCK && req.wdata == nvm_pkg::UNLOCK_FIRST) state_r <= GOT_FIRST;
            end
            GOT_FIRST: begin
               if (req.addr == nvm_pkg::OFS_UNLOCK && req.wdata == nvm_pkg::UNLOCK_SECOND) state_r <= ARMED;
               else if (req.addr == nvm_pkg::OFS_UNLOCK && req.wdata == nvm_pkg::UNLOCK_FIRST) state_r <= GOT_FIRST;
               else state_r <= IDLE;
            end
            default: begin
               state_r <= IDLE;
            end
         endcase
      end else if (req.rd) begin
         state_r <= IDLE;
      end
   end
endmodule : nvm_unlock_seq
`default_nettype wire

// [tb_nvm_access_ctrl.sv]
// Self-checking bench for the nonvolatile access controller.
// Assumes the register port protocol of the design and a short write cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_nvm_access_ctrl;
   logic                 mclk;
   logic                 reset;
   logic [3:0]           reg_addr;
   logic [7:0]           reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   logic [7:0]           reg_rdata;
   logic [7:0]           mem_rdata;
   logic                 abort_write;
   nvm_pkg::mem_cmd_type mem_cmd;
   logic                 irq;
   nvm_pkg::mem_cmd_type seen = '0;
   logic [7:0]           kind;
   int                   n_cmd = 0;
   int                   cycles = 0;
   int                   num_errors = 0;
   int                   n_tests = 0;
   assign kind = {seen.write, seen.erase, seen.read, 3'h0, seen.space};

   nvm_access_ctrl #(.WRITE_CYCLES(10)) i_nvm_access_ctrl (
      .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .abort_write(abort_write),
      .mem_cmd(mem_cmd), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ************************************************************
   // Command capture and hang guard
   // ************************************************************
   always @(posedge mclk) begin
      cycles++;
      if (mem_cmd.write || mem_cmd.erase || mem_cmd.read) begin
         seen <= mem_cmd;
         n_cmd <= n_cmd + 1;
      end
      if (cycles == 3000) begin
         num_errors++;
         results();
      end
   end
   // ************************************************************
   // Bus tasks
   // ************************************************************
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1 chk(reg_rdata, exp);
   endtask : rd_chk
   task automatic launch(input logic [7:0] c);
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_FIRST);
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_SECOND);
      wr(nvm_pkg::OFS_CONTROL, c);
      repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
      #1;
   endtask : launch
   task automatic poll;
      logic [7:0] v;
      v = 8'h02;
      for (int i = 0; i < 40 && v[1] !== 1'b0; i++) begin
         bus(1'b0, 1'b1, nvm_pkg::OFS_CONTROL, 8'h00);
         bus(1'b0, 1'b0, 4'h0, 8'h00);
         #1 v = reg_rdata;
      end
      chk({7'h0, v[1]}, 8'h00);
   endtask : poll
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      mem_rdata = 8'h5a;
      abort_write = 1'b0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      rd_chk(nvm_pkg::OFS_CONTROL, nvm_pkg::CONTROL_RESET);
      rd_chk(nvm_pkg::OFS_IRQ_STAT, 8'h00);
      rd_chk(4'hf, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("test reset done");
      wr(nvm_pkg::OFS_ADDR_LOW, 8'h34);
      wr(nvm_pkg::OFS_ADDR_HIGH, 8'h12);
      wr(nvm_pkg::OFS_CONTROL, 8'h01);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      rd_chk(nvm_pkg::OFS_DATA, 8'h5a);
      chk(seen.addr[15:8], 8'h12);
      chk(seen.addr[7:0], 8'h34);
      chk(kind, 8'h20);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h00);
      wr(nvm_pkg::OFS_CONTROL, 8'h41);
      wr(nvm_pkg::OFS_CONTROL, 8'h81);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h80);
      chk(8'(n_cmd), 8'h01);
      $display("test read done");
      wr(nvm_pkg::OFS_CONTROL, 8'h04);
      wr(nvm_pkg::OFS_CONTROL, 8'h06);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h0c);
      rd_chk(nvm_pkg::OFS_IRQ_STAT, 8'h02);
      wr(nvm_pkg::OFS_CONTROL, 8'h00);
      launch(8'h02);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h08);
      chk(8'(n_cmd), 8'h01);
      wr(nvm_pkg::OFS_CONTROL, 8'h00);
      wr(nvm_pkg::OFS_IRQ_CLR, 8'h03);
      rd_chk(nvm_pkg::OFS_IRQ_STAT, 8'h00);
      $display("test refused start done");
      wr(nvm_pkg::OFS_IRQ_EN, 8'h01);
      wr(nvm_pkg::OFS_DATA, 8'ha5);
      wr(nvm_pkg::OFS_ADDR_LOW, 8'h07);
      wr(nvm_pkg::OFS_CONTROL, 8'h04);
      launch(8'h06);
      wr(nvm_pkg::OFS_CONTROL, 8'h04);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h06);
      poll();
      chk(kind, 8'h80);
      chk({7'h0, seen.start}, 8'h01);
      chk(seen.data, 8'ha5);
      chk(seen.addr[7:0], 8'h07);
      rd_chk(nvm_pkg::OFS_IRQ_STAT, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wr(nvm_pkg::OFS_IRQ_EN, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      #1 chk({7'h0, irq}, 8'h00);
      wr(nvm_pkg::OFS_CONTROL, 8'h00);
      wr(nvm_pkg::OFS_IRQ_CLR, 8'h01);
      $display("test eeprom write done");
      wr(nvm_pkg::OFS_CONTROL, 8'h94);
      launch(8'h96);
      poll();
      chk(kind, 8'h41);
      rd_chk(nvm_pkg::OFS_CONTROL, 8'h84);
      $display("test row erase done");
      wr(nvm_pkg::OFS_CONTROL, 8'hc4);
      launch(8'hc6);
      chk(kind, 8'h82);
      @(posedge mclk);
      abort_write <= 1'b1;
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      abort_write <= 1'b0;
      rd_chk(nvm_pkg::OFS_CONTROL, 8'hcc);
      $display("test abort done");
      results();
   end
endmodule : tb_nvm_access_ctrl
`default_nettype wire
